/* File: hdl/barwc_defs.svh */
// offsets, field positions, codes and length figures of the co-processor pair
`ifndef BARWC_DEFS_SVH
`define BARWC_DEFS_SVH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define BARWC_CTRL_OFS 8'h00
`define BARWC_STAT_OFS 8'h04
`define BARWC_CTRL_HALT_BIT 0
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define BARWC_CMD_RAW 8'h01
`define BARWC_CMD_SOLID 8'h02
`define BARWC_CMD_ROPC 8'h03
`define BARWC_CMD_ROPS 8'h04
// ----------------------------------------------------------------
// lengths in bytes, last header word indexes and the width limit in pixels
// ----------------------------------------------------------------
`define BARWC_LEN_SOLID 32'h0000_0014
`define BARWC_LEN_ROPC 32'h0000_001C
`define BARWC_LEN_RAW_MIN 32'h0000_0014
`define BARWC_LEN_ROPS_MIN 32'h0000_001C
`define BARWC_DW_MIN_LEN 32'h0000_0005
`define BARWC_DW_ADDR_BYTES 32'h0000_0004
`define BARWC_HDR_LAST_SOLID 3'h4
`define BARWC_HDR_LAST_RAW 3'h3
`define BARWC_HDR_LAST_ROPC 3'h6
`define BARWC_HDR_LAST_ROPS 3'h5
`define BARWC_MAX_WIDTH 12'h800
// ----------------------------------------------------------------
// error kinds
// ----------------------------------------------------------------
`define BARWC_ERR_NONE 4'h0
`define BARWC_ERR_LEN 4'h1
`define BARWC_ERR_SHORT 4'h2
`define BARWC_ERR_LONG 4'h3
`define BARWC_ERR_MODE 4'h4
`define BARWC_ERR_SIZE 4'h5
`define BARWC_ERR_DEST 4'h6
`define BARWC_ERR_SRC 4'h7
`define BARWC_ERR_BUS 4'h8
`endif

/* File: hdl/barwc_pkg.sv */
// types shared by the co-processor pair
package barwc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_HDR = 3'b001, ST_CHECK = 3'b010,
      ST_DRAW = 3'b011, ST_DADDR = 3'b100, ST_DDATA = 3'b101,
      ST_RESULT = 3'b110
   } barwc_state_t;
   typedef enum logic [1:0] {
      CM_8 = 2'b00, CM_16 = 2'b01, CM_24 = 2'b10, CM_16UP = 2'b11
   } barwc_cmode_t;
   typedef enum logic [1:0] {
      SRC_CONST = 2'b00, SRC_STREAM = 2'b01,
      SRC_FRM_CONST = 2'b10, SRC_FRM_STREAM = 2'b11
   } barwc_src_t;
   typedef struct packed {
      barwc_state_t st;
      logic halt;
      logic ack;
      logic [31:0] rdat;
      logic [7:0] cmd;
      logic [7:0][31:0] hdr;
      logic [2:0] wi;
      logic [31:0] rem;
      logic [11:0] col;
      logic [11:0] row;
      logic [23:0] acc;
      logic [1:0] nb;
      logic [31:0] w;
      logic [1:0] bp;
      logic have;
      logic rdy;
      logic [28:0] qaddr;
      logic [2:0] off;
      logic [31:0] total;
      logic [31:0] pos;
      logic lane;
      logic first;
      logic fbv;
      logic [63:0] fb_data;
      logic [7:0] fb_be;
      logic [28:0] fb_addr;
      logic pxv;
      logic [11:0] px_x;
      logic [11:0] px_y;
      logic [11:0] px_sx;
      logic [11:0] px_sy;
      logic [23:0] px_color;
      logic [4:0] px_rop;
      barwc_src_t px_src;
      barwc_cmode_t px_mode;
      logic [24:0] px_base;
      logic [24:0] px_sbase;
      logic [15:0] rb16;
      logic res_v;
      logic res_err;
      logic [3:0] kind;
      logic [15:0] wcount;
   } barwc_regs_t;
endpackage

/* File: hdl/barwc_top.sv */
// direct frame-buffer write engine and block-transfer command engine
`timescale 1ns/100ps
`include "barwc_defs.svh"
module barwc_top (
   input logic ref_clk,
   input logic rst,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input logic sel_dram,
   input logic sel_blt,
   input logic [7:0] cmd_code,
   input logic [31:0] cmd_len,
   input logic pl_valid,
   input logic [31:0] pl_data,
   output logic pl_ready,
   output logic res_valid,
   output logic res_err,
   output logic [3:0] engine_error_kind,
   output logic fb_valid,
   output logic [28:0] fb_qaddr,
   output logic [63:0] fb_data,
   output logic [7:0] fb_be,
   input logic fb_ready,
   input logic fb_err,
   output logic px_valid,
   input logic px_ready,
   output logic [11:0] px_x,
   output logic [11:0] px_y,
   output logic [11:0] px_sx,
   output logic [11:0] px_sy,
   output logic [23:0] px_color,
   output logic [4:0] px_rop,
   output barwc_pkg::barwc_src_t px_src,
   output barwc_pkg::barwc_cmode_t px_mode,
   output logic [24:0] px_base,
   output logic [24:0] px_sbase,
   input logic [23:0] rb_pix,
   output logic [15:0] rb_pix16
);
   import barwc_pkg::*;

   barwc_regs_t s, n;
   logic take, err_set, stream, rop, fin_ok;
   logic [3:0] err_code;
   logic [11:0] c_x, c_y, c_w, c_h, c_hres, c_vres, c_sx, c_sy;
   logic [1:0] bppv;
   logic [31:0] cconst;
   logic [3:0] be4;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] widen565(input logic [15:0] c);
      return {c[15:11], 3'b000, c[10:5], 2'b00, c[4:0], 3'b000};
   endfunction

   function automatic logic [15:0] strip888(input logic [23:0] c);
      return {c[23:19], c[15:10], c[7:3]};
   endfunction

   function automatic logic [23:0] colour(input logic [1:0] m,
                                          input logic [31:0] c);
      case (m)
         CM_24: return c[23:0];
         CM_16: return {8'h00, c[15:0]};
         CM_16UP: return widen565(c[15:0]);
         default: return {16'h0000, c[7:0]};
      endcase
   endfunction

   function automatic logic [1:0] bytes_pp(input logic [1:0] m);
      if (m == CM_24) begin
         return 2'd3;
      end else if (m == CM_8) begin
         return 2'd1;
      end
      return 2'd2;
   endfunction

   function automatic logic [31:0] sub4(input logic [31:0] v);
      return (v >= 32'h0000_0004) ? v - 32'h0000_0004 : 32'h0000_0000;
   endfunction

   // ----------------------------------------------------------------
   // command fields
   // ----------------------------------------------------------------
   // only the defined bit ranges are looked at
   // unused bits ignored
   assign c_x = s.hdr[0][11:0];
   assign c_y = s.hdr[0][27:16];
   assign c_w = s.hdr[1][11:0];
   assign c_h = s.hdr[1][27:16];
   assign c_hres = s.hdr[3][11:0];
   assign c_vres = s.hdr[3][27:16];
   assign c_sx = s.hdr[4][11:0];
   assign c_sy = s.hdr[4][27:16];
   assign bppv = bytes_pp(s.hdr[3][15:14]);
   assign stream = (s.cmd == `BARWC_CMD_RAW) || (s.cmd == `BARWC_CMD_ROPS);
   assign rop = (s.cmd == `BARWC_CMD_ROPC) || (s.cmd == `BARWC_CMD_ROPS);
   assign cconst = (s.cmd == `BARWC_CMD_ROPC) ? s.hdr[6] : s.hdr[4];
   assign be4 = {
      (s.pos + 32'd3 >= {29'd0, s.off}) && (s.pos + 32'd3 < s.total),
      (s.pos + 32'd2 >= {29'd0, s.off}) && (s.pos + 32'd2 < s.total),
      (s.pos + 32'd1 >= {29'd0, s.off}) && (s.pos + 32'd1 < s.total),
      (s.pos >= {29'd0, s.off}) && (s.pos < s.total)};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      take = s.rdy && pl_valid;
      err_set = 1'b0;
      err_code = `BARWC_ERR_NONE;
      fin_ok = 1'b0;
      // bus slave: one wait state, unmapped reads give zero
      n.ack = wb_cyc_i && wb_stb_i && !s.ack;
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         if (wb_adr_i == `BARWC_CTRL_OFS) begin
            n.rdat = {31'h0000_0000, s.halt};
         end else if (wb_adr_i == `BARWC_STAT_OFS) begin
            n.rdat = {s.wcount, 5'h00, s.st, 2'b00, s.res_err, s.res_v,
                      s.kind};
         end else begin
            n.rdat = 32'h0000_0000;
         end
      end
      if (s.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `BARWC_CTRL_OFS) begin
         n.halt = wb_dat_i[`BARWC_CTRL_HALT_BIT];
      end
      if (s.fbv && fb_ready) begin
         n.fbv = 1'b0;
      end
      if (s.pxv && px_ready) begin
         n.pxv = 1'b0;
      end
      n.rb16 = strip888(rb_pix);
      case (s.st)
         ST_IDLE: begin
            n.res_v = 1'b0;
            n.res_err = 1'b0;
            n.first = 1'b1;
            n.lane = 1'b0;
            n.have = 1'b0;
            n.nb = 2'd0;
            n.col = 12'h000;
            n.row = 12'h000;
            n.wi = 3'd0;
            n.cmd = cmd_code;
            n.rem = cmd_len;
            if (!s.halt && sel_dram) begin
               n.kind = `BARWC_ERR_NONE;
               n.st = ST_DADDR;
            end else if (!s.halt && sel_blt) begin
               n.kind = `BARWC_ERR_NONE;
               if (cmd_code == `BARWC_CMD_SOLID) begin
                  err_set = cmd_len != `BARWC_LEN_SOLID;
               end else if (cmd_code == `BARWC_CMD_ROPC) begin
                  err_set = cmd_len != `BARWC_LEN_ROPC;
               end else if (cmd_code == `BARWC_CMD_RAW) begin
                  err_set = cmd_len < `BARWC_LEN_RAW_MIN;
               end else if (cmd_code == `BARWC_CMD_ROPS) begin
                  err_set = cmd_len < `BARWC_LEN_ROPS_MIN;
               end
               err_code = `BARWC_ERR_LEN;
               if (cmd_code < `BARWC_CMD_RAW || cmd_code > `BARWC_CMD_ROPS)
               begin
                  err_set = 1'b1;
                  err_code = `BARWC_ERR_MODE;
               end
               if (!err_set) begin
                  n.st = ST_HDR;
               end
            end
         end
         ST_HDR: begin
            if (take) begin
               n.hdr[s.wi] = pl_data;
               n.rem = sub4(s.rem);
               n.wi = s.wi + 3'd1;
               if ((s.cmd == `BARWC_CMD_SOLID &&
                    s.wi == `BARWC_HDR_LAST_SOLID) ||
                   (s.cmd == `BARWC_CMD_RAW && s.wi == `BARWC_HDR_LAST_RAW) ||
                   (s.cmd == `BARWC_CMD_ROPC && s.wi == `BARWC_HDR_LAST_ROPC)
                   || (s.cmd == `BARWC_CMD_ROPS &&
                       s.wi == `BARWC_HDR_LAST_ROPS)) begin
                  n.st = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (c_w == 12'h000 || c_h == 12'h000 ||
                (rop && c_w > `BARWC_MAX_WIDTH)) begin
               err_set = 1'b1;
               err_code = `BARWC_ERR_SIZE;
            end else if ({1'b0, c_x} + {1'b0, c_w} > {1'b0, c_hres} ||
                         {1'b0, c_y} + {1'b0, c_h} > {1'b0, c_vres}) begin
               err_set = 1'b1;
               err_code = `BARWC_ERR_DEST;
            end else if (rop && ({1'b0, c_sx} + {1'b0, c_w} >
                                 {1'b0, c_hres} ||
                                 {1'b0, c_sy} + {1'b0, c_h} >
                                 {1'b0, c_vres})) begin
               err_set = 1'b1;
               err_code = `BARWC_ERR_SRC;
            end else begin
               n.st = ST_DRAW;
            end
            case (s.cmd)
               `BARWC_CMD_SOLID: begin
                  n.px_src = SRC_CONST;
                  n.px_rop = 5'h00;
               end
               `BARWC_CMD_RAW: begin
                  n.px_src = SRC_STREAM;
                  n.px_rop = {1'b0, s.hdr[1][15:12]};
               end
               `BARWC_CMD_ROPC: begin
                  n.px_src = SRC_FRM_CONST;
                  n.px_rop = {1'b0, s.hdr[1][15:12]};
               end
               default: begin
                  n.px_src = SRC_FRM_STREAM;
                  n.px_rop = {s.hdr[1][28], s.hdr[1][15:12]};
               end
            endcase
            n.px_mode = barwc_cmode_t'(s.hdr[3][15:14]);
            n.px_base = s.hdr[2][31:7];
            n.px_sbase = rop ? s.hdr[5][31:7] : 25'h000_0000;
         end
         ST_DRAW: begin
            if (fb_err) begin
               err_set = 1'b1;
               err_code = `BARWC_ERR_BUS;
            end else if (stream && s.nb != bppv) begin
               if (s.have) begin
                  n.acc = {s.acc[15:0], s.w[{s.bp, 3'b000} +: 8]};
                  n.nb = s.nb + 2'd1;
                  n.bp = s.bp + 2'd1;
                  n.have = s.bp != 2'd3;
               end else if (take) begin
                  n.w = pl_data;
                  n.have = 1'b1;
                  n.bp = 2'd0;
                  n.rem = sub4(s.rem);
               end else if (s.rem == 32'h0000_0000) begin
                  err_set = 1'b1;
                  err_code = `BARWC_ERR_SHORT;
               end
            end else if (!s.pxv || px_ready) begin
               n.pxv = 1'b1;
               n.nb = 2'd0;
               n.px_x = c_x + s.col;
               n.px_sx = c_sx + s.col;
               n.px_sy = c_sy + s.row;
               n.px_y = (s.cmd == `BARWC_CMD_RAW && s.hdr[1][31]) ?
                        c_y + c_h - 12'h001 - s.row : c_y + s.row;
               n.px_color = colour(s.hdr[3][15:14],
                                   stream ? {8'h00, s.acc} : cconst);
               if (s.col == c_w - 12'h001) begin
                  n.col = 12'h000;
                  n.have = 1'b0;
                  n.row = s.row + 12'h001;
                  if (s.row == c_h - 12'h001) begin
                     if (stream && s.rem != 32'h0000_0000) begin
                        err_set = 1'b1;
                        err_code = `BARWC_ERR_LONG;
                     end else begin
                        fin_ok = 1'b1;
                     end
                  end
               end else begin
                  n.col = s.col + 12'h001;
               end
            end
         end
         ST_DADDR: begin
            if (take) begin
               n.off = pl_data[2:0];
               n.qaddr = pl_data[31:3];
               n.total = s.rem - `BARWC_DW_ADDR_BYTES;
               n.pos = 32'h0000_0000;
               n.rem = sub4(s.rem);
               if (s.rem < `BARWC_DW_MIN_LEN + {29'd0, pl_data[2:0]}) begin
                  err_set = 1'b1;
                  err_code = `BARWC_ERR_LEN;
               end else begin
                  n.st = ST_DDATA;
               end
            end
         end
         ST_DDATA: begin
            if (fb_err) begin
               err_set = 1'b1;
               err_code = `BARWC_ERR_BUS;
            end else if (s.fbv && fb_ready) begin
               n.qaddr = s.qaddr + 29'd1;
               n.first = 1'b0;
               n.wcount = s.wcount + 16'h0001;
               fin_ok = s.rem == 32'h0000_0000;
            end else if (take) begin
               if (!s.lane) begin
                  n.fb_data[31:0] = pl_data;
                  n.fb_be = {4'h0, be4};
               end else begin
                  n.fb_data[63:32] = pl_data;
                  n.fb_be[7:4] = be4;
               end
               n.pos = s.pos + 32'h0000_0004;
               n.rem = sub4(s.rem);
               if (s.lane || s.rem <= 32'h0000_0004) begin
                  n.fbv = 1'b1;
                  n.fb_addr = s.qaddr;
                  n.lane = 1'b0;
               end else begin
                  n.lane = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (err_set) begin
         n.st = ST_RESULT;
         n.res_v = 1'b1;
         n.res_err = 1'b1;
         n.kind = err_code;
         n.fbv = 1'b0;
      end else if (fin_ok) begin
         n.st = ST_RESULT;
         n.res_v = 1'b1;
      end
      if (s.st != ST_IDLE && !sel_blt && !sel_dram) begin
         n.st = ST_IDLE;
         n.fbv = 1'b0;
         n.pxv = 1'b0;
         n.res_v = 1'b0;
         n.res_err = 1'b0;
      end
      n.rdy = n.st == ST_HDR || n.st == ST_DADDR ||
              (n.st == ST_DDATA && !n.fbv && n.rem != 32'h0000_0000) ||
              (n.st == ST_DRAW && stream && !n.have && n.nb != bppv &&
               n.rem != 32'h0000_0000);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign pl_ready = s.rdy;
   assign res_valid = s.res_v;
   assign res_err = s.res_err;
   assign engine_error_kind = s.kind;
   assign fb_valid = s.fbv;
   assign fb_qaddr = s.fb_addr;
   assign fb_data = s.fb_data;
   assign fb_be = s.fb_be;
   assign px_valid = s.pxv;
   assign px_x = s.px_x;
   assign px_y = s.px_y;
   assign px_sx = s.px_sx;
   assign px_sy = s.px_sy;
   assign px_color = s.px_color;
   assign px_rop = s.px_rop;
   assign px_src = s.px_src;
   assign px_mode = s.px_mode;
   assign px_base = s.px_base;
   assign px_sbase = s.px_sbase;
   assign rb_pix16 = s.rb16;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_dw_len;
      s.st == ST_DADDR && take && sel_dram &&
      s.rem < `BARWC_DW_MIN_LEN + {29'd0, pl_data[2:0]}
      |=> s.st == ST_RESULT && s.res_err && s.kind == 4'h1;
   endproperty
   a_dw_len: assert property (p_dw_len) else $error("short write kept");

   property p_desel;
      s.st != ST_IDLE && !sel_blt && !sel_dram
      |=> s.st == ST_IDLE && !s.fbv && !s.pxv;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect ignored");

   property p_hold;
      s.res_v && (sel_blt || sel_dram) |=> s.res_v && $stable(s.kind);
   endproperty
   a_hold: assert property (p_hold) else $error("result dropped");

   property p_lower_end;
      s.st == ST_DDATA && take && !s.lane && s.rem <= 32'h0000_0004 &&
      !fb_err && (sel_dram || sel_blt) |=> s.fbv && s.fb_be[7:4] == 4'h0;
   endproperty
   a_lower_end: assert property (p_lower_end) else $error("waited pad");

   property p_prepad;
      s.fbv && s.first |-> (s.fb_be & ~(8'hFF << s.off)) == 8'h00;
   endproperty
   a_prepad: assert property (p_prepad) else $error("prepad written");

   property p_width;
      s.st == ST_CHECK && rop && c_w > `BARWC_MAX_WIDTH && sel_blt
      |=> s.kind == 4'h5 && s.res_err;
   endproperty
   a_width: assert property (p_width) else $error("wide rop taken");

   property p_dest;
      s.st == ST_CHECK && c_w != 12'h000 && c_h != 12'h000 && !rop &&
      {1'b0, c_x} + {1'b0, c_w} > {1'b0, c_hres} && sel_blt
      |=> s.kind == 4'h6;
   endproperty
   a_dest: assert property (p_dest) else $error("dest overflow");

   property p_raw_len;
      s.st == ST_IDLE && !s.halt && !sel_dram && sel_blt &&
      cmd_code == `BARWC_CMD_RAW && cmd_len < `BARWC_LEN_RAW_MIN
      |=> s.st == ST_RESULT && s.res_err && s.kind == 4'h1;
   endproperty
   a_raw_len: assert property (p_raw_len) else $error("raw len");

   property p_rop_code;
      $rose(s.pxv) && rop |-> s.px_rop[3:0] == s.hdr[1][15:12];
   endproperty
   a_rop_code: assert property (p_rop_code) else $error("rop code");

   c_dw_ok: cover property (s.st == ST_DDATA ##1 s.res_v && !s.res_err);
   c_blt_err: cover property (s.st == ST_CHECK ##1 s.res_err);
   c_bottom_up: cover property ($rose(s.pxv) && s.hdr[1][31] &&
                                s.cmd == `BARWC_CMD_RAW);
endmodule // barwc_top

/* File: tb/barwc_feed.sv */
// payload source standing in for the command parser
`timescale 1ns/100ps
module barwc_feed (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pl_ready,
   output logic pl_valid,
   output logic [31:0] pl_data
);
   logic [31:0] q[$];
   task automatic push(input logic [31:0] d);
      q.push_back(d);
   endtask
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pl_valid <= 1'b0;
         pl_data <= 32'h0000_0000;
      end else if (!pl_valid || pl_ready) begin
         if (q.size() > 0) begin
            pl_valid <= 1'b1;
            pl_data <= q.pop_front();
         end else begin
            // idle data keeps moving so stale words never match
            pl_valid <= 1'b0;
            pl_data <= ~pl_data;
         end
      end
   end
endmodule // barwc_feed

/* File: tb/blit_and_ram_write_coprocessors_tb.sv */
// self-checking bench for the co-processor pair
`timescale 1ns/100ps
module blit_and_ram_write_coprocessors_tb;
   logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sel_dram;
   logic pl_valid, pl_ready, res_valid, res_err, fb_valid, fb_ready;
   logic sel_blt, fb_err, px_valid;
   logic [3:0] wb_sel_i, engine_error_kind;
   logic [7:0] wb_adr_i, fb_be, cb, cmd_code;
   logic [31:0] wb_dat_i, wb_dat_o, cmd_len, pl_data, rd;
   logic [28:0] fb_qaddr, cq;
   logic [63:0] fb_data, cd;
   logic [11:0] px_x, px_y, px_sx, px_sy;
   logic [23:0] px_color, rb_pix;
   logic [4:0] px_rop;
   logic [1:0] px_src, px_mode;
   logic [24:0] px_base, px_sbase;
   logic [15:0] rb_pix16;
   int miscompares, checked;
   int np = 0;
   // pixel sink shares the frame buffer stall pattern
   barwc_top barwc_top_inst (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .sel_dram, .sel_blt, .cmd_code, .cmd_len, .pl_valid,
      .pl_data, .pl_ready, .res_valid, .res_err, .engine_error_kind,
      .fb_valid, .fb_qaddr, .fb_data, .fb_be, .fb_ready, .fb_err,
      .px_valid, .px_ready(fb_ready), .px_x, .px_y, .px_sx, .px_sy,
      .px_color, .px_rop, .px_src(px_src), .px_mode(px_mode), .px_base,
      .px_sbase, .rb_pix, .rb_pix16);
   barwc_feed barwc_feed_inst (.ref_clk, .rst, .pl_ready, .pl_valid,
      .pl_data);
   always #2 ref_clk = ~ref_clk;
   // frame buffer side stalls every other cycle
   always @(posedge ref_clk) begin
      fb_ready <= !fb_ready;
      if (px_valid && fb_ready) np <= np + 1;
      if (fb_valid && fb_ready) begin
         cb <= fb_be;
         cq <= fb_qaddr;
         cd <= fb_data;
      end
   end
   task automatic stop_test(input bit to);
      if (to) begin
         miscompares++;
         $display("Error at %0t: wait timed out", $time);
      end
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) begin
         n++;
         if (n > 50) stop_test(1);
         @(posedge ref_clk);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic go(input logic b, input logic [7:0] c,
                     input logic [31:0] len);
      int n;
      n = 0;
      sel_dram <= !b;
      sel_blt <= b;
      cmd_code <= c;
      cmd_len <= len;
      @(posedge ref_clk);
      while (res_valid !== 1'b1) begin
         n++;
         if (n > 100) stop_test(1);
         @(posedge ref_clk);
      end
   endtask
   task automatic done;
      sel_dram <= 1'b0;
      sel_blt <= 1'b0;
      repeat (2) @(posedge ref_clk);
      $display("test done at %0t", $time);
   endtask
   task automatic put(input int k, input logic [31:0] a, b, c, d, e, f,
                      g);
      logic [31:0] v[7];
      v = '{a, b, c, d, e, f, g};
      for (int i = 0; i < k; i++) barwc_feed_inst.push(v[i]);
   endtask
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      fb_ready = 1'b0;
      sel_dram = 1'b0;
      cmd_len = 32'h0000_0000;
      sel_blt = 1'b0;
      fb_err = 1'b0;
      cmd_code = 8'h00;
      rb_pix = 24'h80_4008;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_sel_i = 4'h0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0000_0000;
      miscompares = 0;
      checked = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      wb(1'b1, 8'h08, 32'hffff_ffff);
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0001);
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      sel_dram <= 1'b1;
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[10:8], 3'h0);
      done;
      wb(1'b1, 8'h00, 32'h0000_0000);
      chk(rb_pix16, 16'h8201);
      barwc_feed_inst.push(32'h0000_0003);
      barwc_feed_inst.push(32'haabb_ccdd);
      go(1'b0, 8'h08, 32'h0000_0008);
      chk(res_err, 1'b0);
      chk(cb, 8'h08);
      chk(cd[31:0], 32'haabb_ccdd);
      done;
      barwc_feed_inst.push(32'h0000_0104);
      barwc_feed_inst.push(32'h1111_1111);
      barwc_feed_inst.push(32'h5566_7788);
      go(1'b0, 8'h08, 32'h0000_000c);
      chk(cb, 8'hf0);
      chk(cq, 29'h0000_0020);
      chk(cd[63:32], 32'h5566_7788);
      done;
      barwc_feed_inst.push(32'h0000_0003);
      go(1'b0, 8'h08, 32'h0000_0007);
      chk(res_err, 1'b1);
      chk(engine_error_kind, 4'h1);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[5:0], 6'h31);
      done;
      barwc_feed_inst.push(32'h0000_0000);
      barwc_feed_inst.push(32'h0000_0001);
      sel_dram <= 1'b1;
      cmd_len <= 32'h0000_0014;
      repeat (10) @(posedge ref_clk);
      chk(res_valid, 1'b0);
      done;
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[10:8], 3'h0);
      barwc_feed_inst.push(32'h0000_0000);
      fb_err <= 1'b1;
      go(1'b0, 8'h08, 32'h0000_000c);
      chk(engine_error_kind, 4'h8);
      fb_err <= 1'b0;
      done;
      put(5, 32'hf002_f001, 32'hf001_f003, 32'h0000_01ff, 32'h0004_8008,
          32'hff12_3456, 32'h0, 32'h0);
      go(1'b1, 8'h02, 32'h0000_0014);
      chk(res_err, 1'b0);
      done;
      chk(np, 3);
      chk(px_x, 12'h003);
      chk(px_y, 12'h002);
      chk(px_color, 24'h12_3456);
      chk(px_base, 25'h000_0003);
      chk(px_mode, 2'h2);
      put(5, 32'h0000_0007, 32'h0001_0002, 32'h0, 32'h0004_8008, 32'h0,
          32'h0, 32'h0);
      go(1'b1, 8'h02, 32'h0000_0014);
      chk(engine_error_kind, 4'h6);
      done;
      put(6, 32'h0, 32'h8002_0001, 32'h0000_0080, 32'h0002_c008,
          32'haaaa_00f8, 32'h5555_1f00, 32'h0);
      go(1'b1, 8'h01, 32'h0000_0018);
      chk(res_err, 1'b0);
      done;
      chk(np, 5);
      chk(px_y, 12'h000);
      chk(px_color, 24'h00_00f8);
      chk(px_src, 2'h1);
      put(7, 32'h0001_0004, 32'h0001_6002, 32'h0000_0100, 32'h0004_4008,
          32'h0003_0000, 32'h0000_0380, 32'hdead_1234);
      go(1'b1, 8'h03, 32'h0000_001c);
      chk(res_err, 1'b0);
      done;
      chk(np, 7);
      chk({px_sy, px_sx}, 24'h00_3001);
      chk(px_rop, 5'h06);
      chk(px_sbase, 25'h000_0007);
      chk(px_color, 24'h00_1234);
      chk(px_src, 2'h2);
      put(7, 32'h0, 32'h0001_0801, 32'h0, 32'h0004_4008, 32'h0, 32'h0,
          32'h0);
      go(1'b1, 8'h03, 32'h0000_001c);
      chk(engine_error_kind, 4'h5);
      done;
      go(1'b1, 8'h09, 32'h0000_0000);
      chk(engine_error_kind, 4'h4);
      done;
      go(1'b1, 8'h01, 32'h0000_0010);
      chk(engine_error_kind, 4'h1);
      done;
      stop_test(0);
   end
endmodule // blit_and_ram_write_coprocessors_tb
